// ---- rtl/fsd_pkg.sv ----
// constants, types and the decade adder shared by the synthesizer control files
package fsd_pkg;

    // ****************************************************************
    // ring counter and accumulator geometry
    // ****************************************************************
    localparam int RING_LEN    = 10;  // states of the ring counter
    localparam int HALF_LEN    = 5;   // reference clocks in one half cycle
    localparam int ALIGN_POS   = 5;   // ring output that retimes carry and strobe
    localparam int INT_POS     = 6;   // ring output that steps the integer adder
    localparam int DIGIT_W     = 4;   // one bcd decade
    localparam int FRAC_DIGITS = 5;   // decades of the fractional part
    localparam int INT_DIGITS  = 3;   // decades of the integer part
    localparam int FRAC_W      = FRAC_DIGITS * DIGIT_W;
    localparam int INT_W       = INT_DIGITS * DIGIT_W;
    localparam int WORD_W      = FRAC_W + INT_W;
    localparam int FIFO_DEPTH  = 8;   // frequency words waiting for transfer

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [RING_LEN-1:0] RING_RESET = 10'h001;

    // ****************************************************************
    // accumulation phase, one per half cycle
    // ****************************************************************
    typedef enum logic [0:0] {
        FSD_PH_FIRST  = 1'b0,
        FSD_PH_SECOND = 1'b1
    } fsd_phase_t;

    // one decade of decimal addition: {carry, digit}, wraps at ten
    function automatic logic [4:0] fsd_bcd_add(input logic [3:0] a,
                                               input logic [3:0] b,
                                               input logic       c);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, b} + {4'h0, c};
        if (s > 5'h09) begin
            s = s + 5'h06;
        end
        return s;
    endfunction : fsd_bcd_add

endpackage : fsd_pkg

// ---- rtl/fsd_fifo.sv ----
// word fifo with registered read data, valid and ready on both sides
module fsd_fifo
    import fsd_pkg::*;
#(
    parameter int W     = 32,
    parameter int DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
        logic                    out_v;
        logic [W-1:0]            dout;
    } fsd_fifo_st_t;

    fsd_fifo_st_t st_reg;
    fsd_fifo_st_t st_next;
    logic         push;
    logic         take;

    // ****************************************************************
    // storage, pointers and output stage
    // ****************************************************************
    // full stalls the writer; an idle reader lets the fifo really fill
    always_comb begin
        st_next = st_reg;
        push    = in_valid && (st_reg.cnt != (AW + 1)'(DEPTH));
        take    = (st_reg.cnt != '0) && (!st_reg.out_v || out_ready);
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr             = AW'(st_reg.wr + 1'b1);
        end
        if (take) begin
            st_next.dout  = st_reg.mem[st_reg.rd];
            st_next.rd    = AW'(st_reg.rd + 1'b1);
            st_next.out_v = 1'b1;
        end else if (out_ready) begin
            st_next.out_v = 1'b0;
        end
        st_next.cnt = (AW + 1)'(st_reg.cnt + {AW'(0), push} - {AW'(0), take});
    end

    // register the whole state
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign in_ready  = (st_reg.cnt != (AW + 1)'(DEPTH));
    assign out_valid = st_reg.out_v;
    assign out_data  = st_reg.dout;

endmodule : fsd_fifo

// ---- rtl/fsd_ctrl.sv ----
// digital control of the fractional-n local oscillator synthesizer
//
// Overview of operation
// (R1) The 1 MHz reference steps accumulator, latches and storage registers.
// (R2) Ten-state ring counter built from two chained shift stages with feedback.
// (R3) First ring stage delays a one-clock pulse by five reference clocks.
// (R4) Ring yields 50% square wave, ten clocks period, five per half.
// (R5) Complementary half controls gate feedback, result register and carry capture. Code: feedback is ring[9] or an empty ring, not gated by them.
// (R6) 100 kHz phase reference is the last output of the second stage.
// (R7) One ring output retimes adder carry and the strobe alignment flops.
// (R8) Ring pulses step accumulation phases and present decades in turn.
// (R9) Controller sends frequency words on serial data, shift clock and strobe.
// (R10) Strobe passes two flops; holding load lags retimed strobe one clock. Code: load request lags one clock, hold loads from the fifo at ring[9].
// (R11) Serial bits enter at the top decades and shift down on serial clock.
// (R12) Each decade is 4-bit bcd; lowest 1 Hz, top holds 1 and 10 MHz.
// (R13) Controller loads tuned frequency plus offsets; arithmetic absorbs them.
// (R14) Three integer decades drive the divider, five fractional feed accumulator.
// (R15) Fraction realised by averaging: carries select higher ratio per 100,000.
// (R16) Decade terminal count wraps to zero and carries into integer adder.
// (R17) Holding registers keep old word while shifting; update only on load.
module fsd_ctrl
    import fsd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ref_clk_in,
    input  wire logic              ser_clk,
    input  wire logic              ser_data,
    input  wire logic              ser_strobe,
    output logic                   half_ctl,
    output logic                   half_ctl_n,
    output logic                   ref_100k,
    output logic [INT_W-1:0]       int_ratio,
    output logic                   mod_up,
    output logic [FRAC_W-1:0]      frac_res,
    output logic                   load_busy
);

    // ****************************************************************
    // state of the block
    // ****************************************************************
    typedef struct packed {
        logic                  ref_s1;     // reference pin synchroniser
        logic                  ref_s2;
        logic                  ref_prev;   // for edge finding
        logic                  sck_s1;     // serial clock synchroniser
        logic                  sck_s2;
        logic                  sck_prev;
        logic                  sda_s1;     // serial data synchroniser
        logic                  sda_s2;
        logic                  stb_s1;     // strobe, first retiming flop
        logic                  stb_s2;     // strobe, second retiming flop
        logic                  stb_a;      // strobe aligned to the ring
        logic                  stb_b;      // strobe one reference clock later
        logic [RING_LEN-1:0]   ring;       // one-hot ring counter
        fsd_phase_t            phase;      // accumulation phase
        logic [WORD_W-1:0]     shift;      // serial-in chain of decades
        logic                  pend;       // word waiting to enter fifo
        logic [WORD_W-1:0]     hold;       // frequency holding registers
        logic [FRAC_W-1:0]     acc;        // fractional accumulator
        logic                  cin;        // carry between decades
        logic                  carry_cap;  // carry-out of the top decade
        logic                  carry_rt;   // carry retimed by the ring
        logic [INT_W-1:0]      int_ratio;  // integer divide ratio
        logic                  mod_up;     // higher ratio selected
        logic                  half_a;     // first half cycle control
        logic                  half_b;     // second half cycle control
        logic                  ref_100k;   // phase comparator reference
        logic [FRAC_W-1:0]     res;        // result register
    } fsd_state_t;

    fsd_state_t          st_reg;
    fsd_state_t          st_next;
    logic                tick;
    logic                sck_rise;
    logic                load_evt;
    logic                push;
    logic                pop;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic [WORD_W-1:0]   fifo_data;

    // ****************************************************************
    // event strobes from the synchronised pins
    // ****************************************************************
    // a reference edge is the only time base of the ring, strobe alignment and accumulator logic
    assign tick     = st_reg.ref_s2 & ~st_reg.ref_prev;                   // R1
    assign sck_rise = st_reg.sck_s2 & ~st_reg.sck_prev;                   // R11
    // the delayed strobe rises in the tick that copies stb_a into stb_b
    assign load_evt = tick & st_reg.stb_a & ~st_reg.stb_b;                // R10
    // a loaded word waits in pend until the fifo can take it
    assign push     = st_reg.pend & fifo_in_ready;
    // new words only enter at the end of the second half cycle
    assign pop      = tick & st_reg.ring[RING_LEN-1] & fifo_out_valid;    // R17

    // ****************************************************************
    // word buffer between the serial link and the holding registers
    // ****************************************************************
    fsd_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (st_reg.pend),
        .in_ready  (fifo_in_ready),
        .in_data   (st_reg.shift),
        .out_valid (fifo_out_valid),
        .out_ready (tick & st_reg.ring[RING_LEN-1]),
        .out_data  (fifo_data)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [4:0] sum;
        logic       c;
        sum     = 5'h00;
        c       = 1'b0;
        st_next = st_reg;

        // two flops on every pin before any logic looks at it
        st_next.ref_s1   = ref_clk_in;
        st_next.ref_s2   = st_reg.ref_s1;
        st_next.ref_prev = st_reg.ref_s2;
        st_next.sck_s1   = ser_clk;
        st_next.sck_s2   = st_reg.sck_s1;
        st_next.sck_prev = st_reg.sck_s2;
        st_next.sda_s1   = ser_data;
        st_next.sda_s2   = st_reg.sda_s1;
        st_next.stb_s1   = ser_strobe;                                    // R10
        st_next.stb_s2   = st_reg.stb_s1;                                 // R10

        // serial data enter the top decades and move toward 1 Hz
        if (sck_rise) begin
            st_next.shift = {st_reg.sda_s2, st_reg.shift[WORD_W-1:1]};    // R11
        end

        // strobe alignment flop stepped by the ring, then one clock later
        if (tick && st_reg.ring[ALIGN_POS]) begin
            st_next.stb_a = st_reg.stb_s2;                                // R7
        end
        if (tick) begin
            st_next.stb_b = st_reg.stb_a;                                 // R10
        end

        // a new load request wins over the push that clears it
        if (push) begin
            st_next.pend = 1'b0;
        end
        if (load_evt) begin
            st_next.pend = 1'b1;
        end

        // holding registers change only on transfer of a loaded word
        if (pop) begin
            st_next.hold = fifo_data;                                     // R12 R17
        end

        // ring: stage one is ring[4:0], stage two ring[9:5]
        if (tick) begin
            st_next.ring = {st_reg.ring[RING_LEN-2:0], 1'b0};             // R2 R3
            // feedback gating restarts an empty ring
            st_next.ring[0] = st_reg.ring[RING_LEN-1]
                            | ~|st_reg.ring[RING_LEN-2:0];                // R2
        end

        // accumulation steps
        case (st_reg.phase)
            FSD_PH_FIRST: begin
                // one fractional decade per reference clock
                if (tick) begin
                    for (int i = 0; i < FRAC_DIGITS; i++) begin
                        if (st_reg.ring[i]) begin                         // R8
                            c   = (i == 0) ? 1'b0 : st_reg.cin;
                            sum = fsd_bcd_add(st_reg.acc[i*DIGIT_W +: DIGIT_W],
                                              st_reg.hold[i*DIGIT_W +: DIGIT_W],
                                              c);                         // R16
                            st_next.acc[i*DIGIT_W +: DIGIT_W] = sum[3:0];
                            st_next.cin = sum[4];
                            // carry capture only in the first half
                            if (i == FRAC_DIGITS - 1) begin
                                st_next.carry_cap = sum[4];               // R5
                            end
                        end
                    end
                end
            end
            FSD_PH_SECOND: begin
                // result register and carry retiming in the second half
                if (tick && st_reg.ring[ALIGN_POS]) begin
                    st_next.res       = st_reg.acc;                       // R5
                    st_next.carry_rt  = st_reg.carry_cap;                 // R7
                    st_next.carry_cap = 1'b0;
                end
                // integer part plus retimed carry sets the divide ratio
                if (tick && st_reg.ring[INT_POS]) begin
                    c = st_reg.carry_rt;                                  // R15
                    for (int d = 0; d < INT_DIGITS; d++) begin
                        sum = fsd_bcd_add(
                            st_reg.hold[FRAC_W + d*DIGIT_W +: DIGIT_W],
                            4'h0, c);                                     // R14
                        st_next.int_ratio[d*DIGIT_W +: DIGIT_W] = sum[3:0];
                        c = sum[4];
                    end
                    st_next.mod_up = st_reg.carry_rt;                     // R15
                end
            end
            default: begin
                st_next.phase = FSD_PH_FIRST;
            end
        endcase

        // half cycle controls and the 100 kHz reference follow the ring
        st_next.half_a   = |st_next.ring[HALF_LEN-1:0];                   // R4
        st_next.half_b   = ~st_next.half_a;                               // R5
        st_next.phase    = st_next.half_a ? FSD_PH_FIRST : FSD_PH_SECOND; // R8
        st_next.ref_100k = st_next.ring[RING_LEN-1];                      // R6
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg        <= '0;
            st_reg.ring   <= RING_RESET;
            st_reg.half_a <= 1'b1;
            // a reference pin already high at release must not look like an edge
            st_reg.ref_s1   <= 1'b1;
            st_reg.ref_s2   <= 1'b1;
            st_reg.ref_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from the state flops
    assign half_ctl   = st_reg.half_a;
    assign half_ctl_n = st_reg.half_b;
    assign ref_100k   = st_reg.ref_100k;
    assign int_ratio  = st_reg.int_ratio;
    assign mod_up     = st_reg.mod_up;
    assign frac_res   = st_reg.res;
    assign load_busy  = st_reg.pend;

    // ****************************************************************
    // checks
    // ****************************************************************
    // ring holds exactly one set bit
    AST_RING_ONEHOT: assert property (@(posedge clk) disable iff (srst) // R2
        $onehot(st_reg.ring))
        else $error("ring counter not one-hot");

    // ring moves only on a reference edge
    AST_RING_TICK: assert property (@(posedge clk) disable iff (srst) // R1
        !tick |=> $stable(st_reg.ring))
        else $error("ring moved without reference edge");

    // stage one output comes from its fifth position
    AST_STAGE_DELAY: assert property (@(posedge clk) disable iff (srst) // R3
        ($changed(st_reg.ring) && st_reg.ring[HALF_LEN]) |-> $past(st_reg.ring[HALF_LEN-1]))
        else $error("stage one delay wrong");

    // half controls complementary and tied to stage one
    AST_HALF: assert property (@(posedge clk) disable iff (srst) // R4
        (st_reg.half_a == |st_reg.ring[HALF_LEN-1:0]) && (st_reg.half_b != st_reg.half_a))
        else $error("half cycle control wrong");

    // result register written only in the second half
    AST_RES_HALF: assert property (@(posedge clk) disable iff (srst) // R5
        $changed(st_reg.res) |-> $past(st_reg.half_b) && $past(st_reg.ring[ALIGN_POS]))
        else $error("result register written in wrong half");

    // reference is the last ring position
    AST_REF100K: assert property (@(posedge clk) disable iff (srst) // R6
        st_reg.ref_100k == st_reg.ring[RING_LEN-1])
        else $error("100 kHz reference misplaced");

    // aligned strobe changes only at the retiming ring output
    AST_STB_ALIGN: assert property (@(posedge clk) disable iff (srst) // R7
        $changed(st_reg.stb_a) |-> $past(tick) && $past(st_reg.ring[ALIGN_POS]))
        else $error("strobe retimed off the ring output");

    // delayed strobe copies the aligned strobe one reference clock later
    AST_STB_LAG: assert property (@(posedge clk) disable iff (srst) // R10
        $changed(st_reg.stb_b) |-> $past(tick) && (st_reg.stb_b == $past(st_reg.stb_a)))
        else $error("load strobe lag wrong");

    // shift chain moves only on the serial clock
    AST_SHIFT: assert property (@(posedge clk) disable iff (srst) // R11
        $changed(st_reg.shift) |-> $past(sck_rise) && (st_reg.shift[WORD_W-1] == $past(st_reg.sda_s2)))
        else $error("shift chain moved without serial clock");

    // holding registers change only on transfer
    AST_HOLD: assert property (@(posedge clk) disable iff (srst) // R17
        $changed(st_reg.hold) |-> $past(pop))
        else $error("holding registers changed without load");

    // the modulus select changes only at the integer ring step
    AST_MOD: assert property (@(posedge clk) disable iff (srst) // R15
        $changed(st_reg.mod_up) |-> $past(st_reg.ring[INT_POS]) && $past(tick))
        else $error("modulus select changed off its ring step");

    // the word enters the wait slot only on the delayed strobe edge
    AST_LOAD_EVT: assert property (@(posedge clk) disable iff (srst) // R10
        $rose(st_reg.pend) |-> $past(tick) && $past(st_reg.stb_a) && !$past(st_reg.stb_b))
        else $error("load request without delayed strobe edge");

    // fractional decades are added only on reference edges of the first half
    AST_ACC_HALF: assert property (@(posedge clk) disable iff (srst) // R8
        $changed(st_reg.acc) |-> $past(tick) && $past(st_reg.half_a))
        else $error("accumulator stepped outside the first half");

    // carry of the top decade is captured at its own ring step
    AST_CARRY_CAP: assert property (@(posedge clk) disable iff (srst) // R5
        $rose(st_reg.carry_cap) |-> $past(tick) && $past(st_reg.ring[FRAC_DIGITS-1]))
        else $error("carry captured off its ring step");

    // retimed carry moves only at the alignment ring output
    AST_CARRY_RT: assert property (@(posedge clk) disable iff (srst) // R7
        $changed(st_reg.carry_rt) |-> $past(tick) && $past(st_reg.ring[ALIGN_POS]))
        else $error("carry retimed off the ring output");

    // integer ratio is rebuilt only at its ring step
    AST_INT_STEP: assert property (@(posedge clk) disable iff (srst) // R14
        $changed(st_reg.int_ratio) |-> $past(tick) && $past(st_reg.ring[INT_POS]))
        else $error("integer ratio changed off its ring step");

    // a loaded bcd word keeps every accumulated decade decimal
    for (genvar g = 0; g < FRAC_DIGITS; g++) begin : g_bcd
        AST_BCD_DIGIT: assert property (@(posedge clk) disable iff (srst) // R12 R16
            st_reg.acc[g*DIGIT_W +: DIGIT_W] <= 4'h9)
            else $error("accumulator decade beyond nine");
    end

    // main scenarios
    COV_LOAD: cover property (@(posedge clk) disable iff (srst) pop);
    COV_INT_WRAP: cover property (@(posedge clk) disable iff (srst) $rose(st_reg.mod_up) && st_reg.int_ratio == '0);
    COV_CARRY: cover property (@(posedge clk) disable iff (srst) $rose(st_reg.mod_up));
    COV_FULL: cover property (@(posedge clk) disable iff (srst) st_reg.pend && !fifo_in_ready);

endmodule : fsd_ctrl

// ---- testbench/fsd_ser_src.sv ----
// serial controller model that shifts frequency words into the synthesizer control
module fsd_ser_src (
    input  wire logic clk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // idle levels: link clock still, strobe low
    // ****************************************************************
    initial begin
        ser_clk    = 1'b0;
        ser_data   = 1'b1;
        ser_strobe = 1'b0;
    end

    // one frame, lsb of the 1 hz digit first; half sets the link speed in clocks
    task automatic send(input logic [31:0] w, input logic stb, input int half);
        for (int i = 0; i < 32; i++) begin
            ser_data = w[i];
            repeat (half) @(negedge clk);
            ser_clk = 1'b1;
            repeat (half) @(negedge clk);
            ser_clk = 1'b0;
        end
        ser_data = ~w[31];  // released line shows no stale bit
        if (stb) begin
            ser_strobe = 1'b1;
            repeat (1500) @(negedge clk);
            ser_strobe = 1'b0;
            repeat (300) @(negedge clk);
        end
    endtask : send
endmodule : fsd_ser_src

// ---- testbench/fsd_ctrl_tb.sv ----
// self-checking bench: ring timing, serial load and accumulator against a model
module fsd_ctrl_tb
    import fsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // clocks, design and serial source
    // ****************************************************************
    logic              clk        = 1'b0;
    logic              srst       = 1'b1;
    logic              ref_clk_in = 1'b0;
    logic              ser_clk;
    logic              ser_data;
    logic              ser_strobe;
    logic              half_ctl;
    logic              half_ctl_n;
    logic              ref_100k;
    logic              mod_up;
    logic              load_busy;
    logic [INT_W-1:0]  int_ratio;
    logic [FRAC_W-1:0] frac_res;
    logic [31:0]       rng        = 32'h0000_0008;
    int                fails      = 0;
    int                n_checks   = 0;
    wire  [2:0]        mon        = {load_busy, ref_100k, half_ctl};

    // system clock, and a 1 MHz reference stepped on falling edges
    always #4 clk = ~clk;
    initial begin
        forever begin
            repeat (62) @(negedge clk);
            ref_clk_in = 1'b1;
            repeat (63) @(negedge clk);
            ref_clk_in = 1'b0;
        end
    end

    fsd_ctrl dut (.clk(clk), .srst(srst), .ref_clk_in(ref_clk_in), .ser_clk(ser_clk),
                  .ser_data(ser_data), .ser_strobe(ser_strobe), .half_ctl(half_ctl),
                  .half_ctl_n(half_ctl_n), .ref_100k(ref_100k), .int_ratio(int_ratio),
                  .mod_up(mod_up), .frac_res(frac_res), .load_busy(load_busy));
    fsd_ser_src src (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_strobe(ser_strobe));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic conclude();
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // bounded wait for a watched output to reach a level; cnt is clocks spent
    task automatic wait_lvl(input int b, input logic v, output int cnt);
        cnt = 0;
        while (mon[b] !== v) begin
            @(negedge clk);
            cnt++;
            if (cnt > 3000) begin
                fails++;
                conclude();
            end
        end
    endtask : wait_lvl

    function automatic logic [31:0] to_bcd(input int v);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction : to_bcd

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs

    task automatic do_reset();
        @(negedge clk);
        srst = 1'b1;
        repeat (3) @(negedge clk);
        check("reset outputs", {half_ctl, half_ctl_n, ref_100k, mod_up, load_busy, int_ratio, frac_res},
              40'h10_0000_0000);
        srst = 1'b0;
    endtask : do_reset

    // load one word, then follow eight ring turns against the decimal model
    task automatic run(input int f, input int ip, input int half);
        int c;
        int acc;
        int cy;
        do_reset();
        fork
            src.send(to_bcd(ip * 100000 + f), 1'b1, half);
        join_none
        wait_lvl(2, 1, c);
        wait_lvl(2, 0, c);
        check("load_busy clocks", c, 1);
        wait_lvl(1, 0, c);
        wait_lvl(1, 1, c);
        acc = 0;
        for (int k = 1; k <= 8; k++) begin
            if (k == 2) begin
                fork
                    src.send(~to_bcd(ip * 100000 + f), 1'b0, half);
                join_none
            end
            wait_lvl(1, 0, c);
            check("ref_100k high", c, 125);
            wait_lvl(1, 1, c);
            check("ref_100k low", c, 1125);
            acc = acc + f;
            cy = (acc >= 100000) ? 1 : 0;
            acc = acc % 100000;
            check("frac_res", frac_res, to_bcd(acc) & 32'h000f_ffff);
            check("int_ratio", int_ratio, to_bcd((ip + cy) % 1000) & 32'h0000_0fff);
            check("mod_up", mod_up, cy);
        end
    endtask : run

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        int c;
        int f;
        int ip;
        int fs[4];
        int is[4];
        fs = '{50000, 99999, 23467, 0};
        is = '{501, 999, 501, 404};
        do_reset();
        wait_lvl(0, 0, c);
        wait_lvl(0, 1, c);
        check("half pair high", {half_ctl, half_ctl_n}, 40'h2);
        wait_lvl(0, 0, c);
        check("half high clocks", c, 625);
        check("half pair low", {half_ctl, half_ctl_n}, 40'h1);
        wait_lvl(0, 1, c);
        check("half low clocks", c, 625);
        for (int i = 0; i < 5; i++) begin
            if (i < 4) begin
                f = fs[i];
                ip = is[i];
            end else begin
                rng = xs(rng);
                f = int'(rng % 32'd100000);
                rng = xs(rng);
                ip = int'(rng % 32'd1000);
            end
            run(f, ip, 10);
        end
        conclude();
    end
endmodule : fsd_ctrl_tb
